/* File: design/tpw_pkg.sv */
// constants, types and register map of the standard timer block
package tpw_pkg;

    // register byte addresses on the avalon slave
    localparam logic [7:0] ADDR_CTL0   = 8'h00;
    localparam logic [7:0] ADDR_CTL1   = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
    localparam logic [7:0] ADDR_CMPA_L = 8'h10;
    localparam logic [7:0] ADDR_CMPA_H = 8'h14;
    localparam logic [7:0] ADDR_CMPP   = 8'h18;
    localparam logic [7:0] ADDR_FLAGS  = 8'h1C;

    // timer_control_0 fields
    localparam int CTL0_PAUSE_BIT = 7;
    localparam int CTL0_CLK_LSB   = 4;
    localparam int CTL0_ON_BIT    = 3;

    // timer_control_1 fields
    localparam int CTL1_MODE_LSB = 6;
    localparam int CTL1_IO_LSB   = 4;
    localparam int CTL1_OC_BIT   = 3;
    localparam int CTL1_POL_BIT  = 2;
    localparam int CTL1_DPX_BIT  = 1;
    localparam int CTL1_CLR_BIT  = 0;

    // flag register fields, write one to clear
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;

    // reset values
    localparam logic [7:0]  CTL_RESET = 8'h00;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // prescaler terminal counts and the pwm duty used when compare P is zero
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [3:0] DIV16_LAST = 4'hF;
    localparam logic [5:0] DIV64_LAST = 6'h3F;
    localparam logic [16:0] P_ZERO_DUTY = 17'h1_0000;

    typedef enum logic [1:0] {
        TPW_MODE_CMP   = 2'b00,
        TPW_MODE_UNDEF = 2'b01,
        TPW_MODE_PWM   = 2'b10,
        TPW_MODE_TMR   = 2'b11
    } tpw_mode_t;

    typedef enum logic [2:0] {
        TPW_CLK_SYS4  = 3'b000,
        TPW_CLK_SYS   = 3'b001,
        TPW_CLK_H16   = 3'b010,
        TPW_CLK_H64   = 3'b011,
        TPW_CLK_TBC   = 3'b100
    } tpw_clk_t;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } tpw_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } tpw_av_rsp_t;

endpackage : tpw_pkg

/* File: design/tpw_timer.sv */
// standard 16-bit timer with compare, pwm, single pulse and timer modes
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
module tpw_timer
    import tpw_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // internal clocks from other domains
    input  wire logic                 high_clock,
    input  wire logic                 time_base_clock,
    // avalon slave
    input  wire tpw_pkg::tpw_av_req_t av_req,
    output tpw_pkg::tpw_av_rsp_t      av_rsp,
    // output pin
    output logic                      pin_out,
    output logic                      pin_oe_n
);
    import tpw_pkg::*;

    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [15:0] counter;
    logic [15:0] cmp_a;
    logic [7:0]  cmp_p;
    logic        flag_a;
    logic        flag_p;
    logic        on_prev;
    logic        ack;
    logic [31:0] rdata;
    logic [2:0]  h_sync;
    logic [2:0]  t_sync;
    logic [1:0]  div4;
    logic [5:0]  hdiv;
    logic        cmp_level;

    logic        on_bit;
    logic        pause_bit;
    tpw_clk_t    clock_select_field;
    tpw_mode_t   mode_field;
    logic [1:0]  output_function_field;
    logic        output_control_bit;
    logic        polarity_bit;
    logic        period_duty_swap_bit;
    logic        clear_select_bit;

    logic        h_edge;
    logic        t_edge;
    logic        tick;
    logic        on_rise;
    logic        cnt_en;
    logic [15:0] next_count;
    logic        match_a;
    logic        match_p;
    logic        clear_now;
    logic        cmp_like;
    logic        is_pwm;
    logic        is_single;
    logic        single_stop;
    logic [16:0] duty_val;
    logic        pwm_hi;
    logic        pwm_active;
    logic        pwm_level;
    logic        next_on;
    logic        bus_rd;
    logic        bus_wr;
    logic        wr_lane0;
    logic [31:0] next_rdata;

    assign on_bit                = ctl0[CTL0_ON_BIT];
    assign pause_bit             = ctl0[CTL0_PAUSE_BIT];
    assign clock_select_field    = tpw_clk_t'(ctl0[CTL0_CLK_LSB +: 3]);
    assign mode_field            = tpw_mode_t'(ctl1[CTL1_MODE_LSB +: 2]);
    assign output_function_field = ctl1[CTL1_IO_LSB +: 2];
    assign output_control_bit    = ctl1[CTL1_OC_BIT];
    assign polarity_bit          = ctl1[CTL1_POL_BIT];
    assign period_duty_swap_bit  = ctl1[CTL1_DPX_BIT];
    assign clear_select_bit      = ctl1[CTL1_CLR_BIT];

    // bus slave: one wait state, access completes when waitrequest is low
    assign av_rsp             = '{readdata:    rdata,
                                  waitrequest: (av_req.read | av_req.write) & ~ack};
    assign bus_rd             = av_req.read & ack;
    assign bus_wr             = av_req.write & ack;
    assign wr_lane0           = bus_wr & av_req.byteenable[0];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (av_req.read | av_req.write) & ~ack;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (av_req.address)
            ADDR_CTL0:   next_rdata[7:0] = {ctl0[7:3], 3'b000};
            ADDR_CTL1:   next_rdata[7:0] = ctl1;
            ADDR_CNT_LO: next_rdata[7:0] = counter[7:0];
            ADDR_CNT_HI: next_rdata[7:0] = counter[15:8];
            ADDR_CMPA_L: next_rdata[7:0] = cmp_a[7:0];
            ADDR_CMPA_H: next_rdata[7:0] = cmp_a[15:8];
            ADDR_CMPP:   next_rdata[7:0] = cmp_p;
            ADDR_FLAGS:  next_rdata[1:0] = {flag_p, flag_a};
            default:     next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (av_req.read & ~ack) begin
            rdata <= next_rdata;
        end
    end

    // single pulse ends by match A clearing the on bit; a software write wins
    always_comb begin
        next_on = on_bit;
        if (wr_lane0 && av_req.address == ADDR_CTL0) begin
            next_on = av_req.writedata[CTL0_ON_BIT];
        end else if (single_stop) begin
            next_on = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl0 <= CTL_RESET;
        end else begin
            if (wr_lane0 && av_req.address == ADDR_CTL0) begin
                ctl0[7:4] <= av_req.writedata[7:4];
            end
            ctl0[CTL0_ON_BIT] <= next_on;
            ctl0[2:0]         <= 3'b000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl1  <= CTL_RESET;
            cmp_a <= CNT_RESET;
            cmp_p <= BYTE_ZERO;
        end else if (wr_lane0) begin
            case (av_req.address)
                ADDR_CTL1:   ctl1 <= av_req.writedata[7:0];
                ADDR_CMPA_L: cmp_a[7:0] <= av_req.writedata[7:0];
                ADDR_CMPA_H: cmp_a[15:8] <= av_req.writedata[7:0];
                ADDR_CMPP:   cmp_p <= av_req.writedata[7:0];
                default:     ;
            endcase
        end
    end

    // two-flop synchronisers plus an edge history flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            h_sync <= 3'b000;
            t_sync <= 3'b000;
        end else begin
            h_sync <= {h_sync[1:0], high_clock};
            t_sync <= {t_sync[1:0], time_base_clock};
        end
    end

    assign h_edge = h_sync[1] & ~h_sync[2];
    assign t_edge = t_sync[1] & ~t_sync[2];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div4 <= 2'b00;
            hdiv <= 6'h00;
        end else begin
            div4 <= div4 + 2'b01;
            if (h_edge) begin
                hdiv <= hdiv + 6'h01;
            end
        end
    end

    always_comb begin
        case (clock_select_field)
            TPW_CLK_SYS4: tick = (div4 == DIV4_LAST);
            TPW_CLK_SYS:  tick = 1'b1;
            TPW_CLK_H16:  tick = h_edge & (hdiv[3:0] == DIV16_LAST);
            TPW_CLK_H64:  tick = h_edge & (hdiv == DIV64_LAST);
            TPW_CLK_TBC:  tick = t_edge;
            default:      tick = 1'b0;
        endcase
    end

    // mode decode
    always_comb begin
        case (mode_field)
            TPW_MODE_CMP: begin
                cmp_like = 1'b1;
                is_pwm   = 1'b0;
            end
            TPW_MODE_PWM: begin
                cmp_like = 1'b0;
                is_pwm   = 1'b1;
            end
            default: begin
                cmp_like = 1'b1;
                is_pwm   = 1'b0;
            end
        endcase
    end

    assign is_single   = is_pwm & (output_function_field == 2'b11);
    assign on_rise     = on_bit & ~on_prev;
    assign cnt_en      = on_bit & ~pause_bit & tick & ~on_rise;
    assign next_count  = counter + 16'h0001;
    assign match_a     = cnt_en & (next_count == cmp_a);
    assign match_p     = cnt_en & (next_count == {cmp_p, 8'h00});
    assign single_stop = is_single & match_a;

    // clear source: clear select in compare/timer, swap bit in pwm, no clear in single pulse
    always_comb begin
        if (cmp_like) begin
            clear_now = clear_select_bit ? match_a : match_p;
        end else if (is_single) begin
            clear_now = 1'b0;
        end else begin
            clear_now = period_duty_swap_bit ? match_a : match_p;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            on_prev <= 1'b0;
        end else begin
            on_prev <= on_bit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counter <= CNT_RESET;
        end else if (on_rise) begin
            counter <= CNT_RESET;
        end else if (cnt_en) begin
            counter <= clear_now ? CNT_RESET : next_count;
        end
    end

    // sticky flags, a new match wins over a same-cycle clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_a <= 1'b0;
            flag_p <= 1'b0;
        end else begin
            flag_a <= match_a |
                (flag_a & ~(wr_lane0 && av_req.address == ADDR_FLAGS &&
                            av_req.writedata[FLAG_A_BIT]));
            flag_p <= (match_p & ~(cmp_like & clear_select_bit) & ~is_single) |
                (flag_p & ~(wr_lane0 && av_req.address == ADDR_FLAGS &&
                            av_req.writedata[FLAG_P_BIT]));
        end
    end

    // compare mode pin level, loaded from the output control bit on enable, then moved by match A only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmp_level <= 1'b0;
        end else if (on_rise && mode_field == TPW_MODE_CMP) begin
            cmp_level <= output_control_bit;
        end else if (match_a && mode_field == TPW_MODE_CMP) begin
            case (output_function_field)
                2'b01:   cmp_level <= 1'b0;
                2'b10:   cmp_level <= 1'b1;
                2'b11:   cmp_level <= ~cmp_level;
                default: cmp_level <= cmp_level;
            endcase
        end
    end

    // pwm duty: counter below duty value means active
    assign duty_val = period_duty_swap_bit ?
        ((cmp_p == BYTE_ZERO) ? P_ZERO_DUTY : {1'b0, cmp_p, 8'h00}) :
        {1'b0, cmp_a};
    assign pwm_hi   = ({1'b0, counter} < duty_val);

    always_comb begin
        case (output_function_field)
            2'b00:   pwm_active = 1'b0;
            2'b01:   pwm_active = 1'b1;
            2'b10:   pwm_active = pwm_hi;
            default: pwm_active = on_bit;
        endcase
    end

    assign pwm_level = pwm_active ? output_control_bit : ~output_control_bit;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_out  <= (is_pwm ? pwm_level : cmp_level) ^ polarity_bit;
            pin_oe_n <= ~(is_pwm | (mode_field == TPW_MODE_CMP));
        end
    end

    chk_reserved_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctl0[6:4] > 3'b100) |-> !tick) else $error("reserved clock still ticks");

    chk_on_rise_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        on_rise |=> (counter == CNT_RESET)) else $error("counter not cleared on enable");

    chk_off_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !on_bit |=> (counter == $past(counter))) else $error("counter moved while off");

    chk_pause_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pause_bit && !on_rise) |=> $stable(counter)) else $error("counter moved in pause");

    chk_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cnt_en && !clear_now) |=> (counter == $past(counter) + 16'h0001))
        else $error("counter did not step by one");

    chk_clear_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmp_like && clear_select_bit && match_a && !on_rise) |=> (counter == CNT_RESET))
        else $error("match A did not clear counter");

    chk_toggle_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_field == TPW_MODE_CMP && match_a && !on_rise && output_function_field == 2'b11)
        |=> (cmp_level != $past(cmp_level))) else $error("toggle did not toggle");

    chk_no_p_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmp_like && clear_select_bit && !flag_p) |=> !flag_p)
        else $error("P flag set with A clearing");

    chk_pin_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_field == TPW_MODE_CMP) |=> (pin_out == ($past(cmp_level) ^ $past(polarity_bit))))
        else $error("pin level wrong");

    chk_single_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (single_stop && !(wr_lane0 && av_req.address == ADDR_CTL0)) |=> !on_bit)
        else $error("single pulse did not end");

    chk_ctl0_low_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus_rd && av_req.address == ADDR_CTL0) |-> (rdata[2:0] == 3'b000))
        else $error("unimplemented bits read nonzero");

endmodule : tpw_timer

/* File: tb/tpw_timer_tb.sv */
// self-checking testbench for the standard timer block
module tpw_timer_tb;
    import tpw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys;
    logic        rst_n;
    logic        high_clock;
    logic        time_base_clock;
    tpw_av_req_t av_req;
    tpw_av_rsp_t av_rsp;
    logic        pin_out;
    logic        pin_oe_n;
    int          err_total;
    int          checks_done;

    tpw_timer u_tpw_timer (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .high_clock      (high_clock),
        .time_base_clock (time_base_clock),
        .av_req          (av_req),
        .av_rsp          (av_rsp),
        .pin_out         (pin_out),
        .pin_oe_n        (pin_oe_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // slower internal clocks, unrelated in phase to the system clock
    initial begin
        high_clock = 1'b0;
        forever #12.3 high_clock = ~high_clock;
    end
    initial begin
        time_base_clock = 1'b0;
        forever #100 time_base_clock = ~time_base_clock;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] g);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            err_total++;
            $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    // one avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        av_req.address    <= a;
        av_req.read       <= ~wr;
        av_req.write      <= wr;
        av_req.writedata  <= {24'h00_0000, d};
        av_req.byteenable <= 4'hF;
        do begin
            @(posedge clk_sys);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("unexpected waitrequest expected 0 seen %b", av_rsp.waitrequest);
            stop_test();
        end
        q = av_rsp.readdata[7:0];
        if (!wr) begin
            chk("readdata upper", 16'h0000, av_rsp.readdata[31:16]);
        end
        av_req.read  <= 1'b0;
        av_req.write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        logic [7:0] v;
        bus(1'b0, a, 8'h00, v);
        q = {8'h00, v};
    endtask : rd

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [15:0] q;
        rd(a, q);
        chk(nm, {8'h00, e}, q);
    endtask : rd_chk

    task automatic rd_cnt(output logic [15:0] q);
        logic [15:0] lo;
        logic [15:0] hi;
        rd(ADDR_CNT_LO, lo);
        rd(ADDR_CNT_HI, hi);
        q = {hi[7:0], lo[7:0]};
    endtask : rd_cnt

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // cycles until the pin changes level
    task automatic wait_change(output int n);
        logic p;
        n = 0;
        p = pin_out;
        do begin
            @(negedge clk_sys);
            n++;
        end while (pin_out === p && n < 3000);
        if (n >= 3000) begin
            err_total++;
            $display("unexpected pin_out expected change seen none");
            stop_test();
        end
    endtask : wait_change

    task automatic count_high(input int n, output logic [15:0] h);
        h = 16'h0000;
        repeat (n) begin
            @(negedge clk_sys);
            if (pin_out === 1'b1) h++;
        end
    endtask : count_high

    task automatic t_regs;
        rd_chk("ctl0", ADDR_CTL0, 8'h00);
        rd_chk("ctl1", ADDR_CTL1, 8'h00);
        rd_chk("cnt_lo", ADDR_CNT_LO, 8'h00);
        rd_chk("cnt_hi", ADDR_CNT_HI, 8'h00);
        rd_chk("cmpa_lo", ADDR_CMPA_L, 8'h00);
        rd_chk("cmpa_hi", ADDR_CMPA_H, 8'h00);
        rd_chk("cmpp", ADDR_CMPP, 8'h00);
        wr(ADDR_CTL0, 8'hFF);
        rd_chk("ctl0 low bits", ADDR_CTL0, 8'hF8);
        wr(ADDR_CTL0, 8'h00);
        wr(ADDR_CNT_LO, 8'h55);
        rd_chk("cnt_lo ro", ADDR_CNT_LO, 8'h00);
        wr(8'h20, 8'h77);
        rd_chk("unmapped", 8'h20, 8'h00);
        wr(ADDR_CMPA_H, 8'hA5);
        rd_chk("cmpa_hi rw", ADDR_CMPA_H, 8'hA5);
        wr(ADDR_CMPP, 8'h3C);
        rd_chk("cmpp rw", ADDR_CMPP, 8'h3C);
        wr(ADDR_CTL1, 8'hFF);
        rd_chk("ctl1 rw", ADDR_CTL1, 8'hFF);
        wr(ADDR_CTL1, 8'h00);
        wr(ADDR_CMPA_H, 8'h00);
        wr(ADDR_CMPP, 8'h00);
        $display("test registers done");
    endtask : t_regs

    task automatic t_clksel;
        int lo [8] = '{158, 638, 11, 2, 24, 0, 0, 0};
        int hi [8] = '{166, 648, 15, 4, 28, 0, 0, 0};
        logic [15:0] q;
        wr(ADDR_CTL1, 8'hC0);
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_CTL0, 8'h00);
            wr(ADDR_CTL0, {1'b0, 3'(s), 4'h8});
            cyc(640);
            rd_cnt(q);
            chk_rng("count per clock source", lo[s], hi[s], q);
        end
        $display("test clock select done");
    endtask : t_clksel

    task automatic t_on_pause;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CTL0, 8'h18);
        cyc(100);
        rd_cnt(a);
        wr(ADDR_CTL0, 8'h10);
        rd_cnt(b);
        cyc(20);
        rd_cnt(c);
        chk("count while off", b, c);
        chk_rng("count kept when off", a + 1, a + 12, b);
        wr(ADDR_CTL0, 8'h18);
        rd_cnt(a);
        chk_rng("count after on rise", 0, 8, a);
        cyc(100);
        wr(ADDR_CTL0, 8'h98);
        rd_cnt(b);
        cyc(20);
        rd_cnt(c);
        chk("count while paused", b, c);
        wr(ADDR_CTL0, 8'h18);
        rd_cnt(c);
        chk_rng("count after resume", b, b + 10, c);
        $display("test on and pause done");
    endtask : t_on_pause

    task automatic t_cmp_levels;
        wr(ADDR_CMPA_L, 8'h10);
        for (int io = 0; io < 3; io++) begin
            for (int pol = 0; pol < 2; pol++) begin
                wr(ADDR_CTL0, 8'h10);
                wr(ADDR_CTL1, {2'b00, 2'(io), 1'b0, 1'(pol), 2'b01});
                wr(ADDR_CTL0, 8'h18);
                cyc(3);
                chk("initial level", 16'(pol), {15'h0000, pin_out});
                chk("pin enable", 16'h0000, {15'h0000, pin_oe_n});
                cyc(40);
                chk("level after match", 16'((io == 2) ^ pol), {15'h0000, pin_out});
            end
        end
        $display("test compare levels done");
    endtask : t_cmp_levels

    task automatic t_cmp_period(input logic clr, input logic [7:0] a, input logic [7:0] p,
                                input int per, input logic [7:0] flg);
        int n;
        logic [15:0] q;
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CMPA_L, a);
        wr(ADDR_CMPP, p);
        wr(ADDR_CTL1, {7'b0011_100, clr});
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CTL0, 8'h18);
        wait_change(n);
        wait_change(n);
        chk("toggle interval", 16'(per), 16'(n));
        rd(ADDR_FLAGS, q);
        chk("flags", {8'h00, flg}, q);
        $display("test compare period done");
    endtask : t_cmp_period

    task automatic t_pwm;
        logic [7:0]  c1 [3] = '{8'h88, 8'h98, 8'h9C};
        logic [15:0] lv [3] = '{16'h0000, 16'h0001, 16'h0000};
        logic [15:0] h;
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CMPA_L, 8'h40);
        wr(ADDR_CMPP, 8'h01);
        wr(ADDR_CTL1, 8'hA9);
        wr(ADDR_CTL0, 8'h18);
        cyc(300);
        count_high(256, h);
        chk("pwm high cycles swap 0", 16'd64, h);
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CMPA_L, 8'h00);
        wr(ADDR_CMPA_H, 8'h02);
        wr(ADDR_CTL1, 8'hAA);
        wr(ADDR_CTL0, 8'h18);
        cyc(600);
        count_high(512, h);
        chk("pwm high cycles swap 1", 16'd256, h);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTL0, 8'h10);
            wr(ADDR_CTL1, c1[i]);
            wr(ADDR_CTL0, 8'h18);
            cyc(3);
            chk("pwm forced level", lv[i], {15'h0000, pin_out});
        end
        $display("test pwm done");
    endtask : t_pwm

    task automatic t_single;
        logic [15:0] h;
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CMPA_H, 8'h00);
        wr(ADDR_CMPA_L, 8'h20);
        wr(ADDR_CTL1, 8'hB8);
        wr(ADDR_CTL0, 8'h18);
        count_high(100, h);
        chk_rng("single pulse width", 30, 36, h);
        rd_chk("on bit after pulse", ADDR_CTL0, 8'h10);
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CTL1, 8'hC0);
        wr(ADDR_CTL0, 8'h18);
        cyc(3);
        chk("pin enable timer mode", 16'h0001, {15'h0000, pin_oe_n});
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CTL1, 8'h40);
        wr(ADDR_CTL0, 8'h18);
        cyc(3);
        chk("pin enable undefined mode", 16'h0001, {15'h0000, pin_oe_n});
        $display("test single pulse and timer mode done");
    endtask : t_single

    initial begin
        err_total   = 0;
        checks_done = 0;
        rst_n       = 1'b0;
        av_req      = '0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_clksel();
        t_on_pause();
        t_cmp_levels();
        t_cmp_period(1'b1, 8'h10, 8'h00, 16, 8'h01);
        t_cmp_period(1'b0, 8'h80, 8'h01, 256, 8'h03);
        t_pwm();
        t_single();
        stop_test();
    end
endmodule : tpw_timer_tb
